// ### ivs_top.v
/*
 interrupt recognition, priority resolution, register stacking and vector
 fetch for an 8-bit cpu. assumes the cpu core presents its registers,
 raises insn_done_i at each instruction boundary, accepts one memory write or
 read per cycle with read data in the cycle after the strobe, and that
 peripherals hold their flags until software clears them.
*/
`timescale 1ns/1ps
`include "ivs_defines.vh"

module ivs_top (
	// clock and reset
	input  wire        ref_clk_i,
	input  wire        nrst_i,
	// reset-class and nonmaskable sources
	input  wire        wdog_fail_i,
	input  wire        watchdog_disable_i,
	input  wire        clkmon_fail_i,
	input  wire        clock_monitor_enable_i,
	input  wire        nonmaskable_pin_request_n_i,
	input  wire        illegal_op_i,
	input  wire        software_trap_i,
	// maskable flags and local enables
	input  wire        irq_pin_n_i,
	input  wire        periodic_flag_i,
	input  wire        periodic_irq_enable_i,
	input  wire [3:0]  cap_flag_i,
	input  wire        cap1_irq_enable_i,
	input  wire        cap2_irq_enable_i,
	input  wire        cap3_irq_enable_i,
	input  wire        cap4_cmp5_irq_enable_i,
	input  wire [3:0]  cmp_flag_i,
	input  wire        cmp1_irq_enable_i,
	input  wire        cmp2_irq_enable_i,
	input  wire        cmp3_irq_enable_i,
	input  wire        cmp4_irq_enable_i,
	input  wire        t1_ovf_flag_i,
	input  wire        t1_overflow_enable_i,
	input  wire [2:0]  t2_cmp_flag_i,
	input  wire [2:0]  t2_cmp_enable_i,
	input  wire        t2_c4_flag_i,
	input  wire        t2_chan4_irq_enable_i,
	input  wire        t2_ovf_flag_i,
	input  wire        t2_overflow_enable_i,
	input  wire [3:0]  t3_cc_flag_i,
	input  wire [3:0]  t3_cc_enable_i,
	input  wire        t3_ovf_flag_i,
	input  wire        t3_overflow_enable_i,
	input  wire        pa_ovf_flag_i,
	input  wire        pulse_ovf_irq_enable_i,
	input  wire        pa_edge_flag_i,
	input  wire        pulse_edge_irq_enable_i,
	input  wire        sync_done_flag_i,
	input  wire        sync_serial_irq_enable_i,
	input  wire        rx_full_flag_i,
	input  wire        rx_overrun_flag_i,
	input  wire        rx_irq_enable_i,
	input  wire        tx_empty_flag_i,
	input  wire        tx_empty_irq_enable_i,
	input  wire        tx_done_flag_i,
	input  wire        tx_done_irq_enable_i,
	input  wire        idle_line_flag_i,
	input  wire        idle_line_irq_enable_i,
	// serial clear sequence observation
	input  wire        ser_status_rd_i,
	input  wire        ser_data_rd_i,
	output reg         rx_full_clear_o,
	// priority select port
	input  wire [4:0]  psel_wdata_i,
	input  wire        psel_wr_i,
	output reg  [4:0]  psel_o,
	// cpu register file and instruction flow
	input  wire        insn_done_i,
	input  wire        rti_i,
	input  wire        cc_wr_i,
	input  wire [7:0]  cc_wdata_i,
	input  wire [15:0] sp_i,
	input  wire [15:0] pc_i,
	input  wire [15:0] y_index_i,
	input  wire [15:0] x_index_i,
	input  wire [7:0]  accumulator_a_i,
	input  wire [7:0]  accumulator_b_i,
	output reg  [7:0]  condition_codes_o,
	// memory port
	output reg  [15:0] mem_addr_o,
	output reg  [7:0]  mem_wdata_o,
	output reg         mem_wr_o,
	output reg         mem_rd_o,
	input  wire [7:0]  mem_rdata_i,
	// results to cpu
	output wire        cpu_hold_o,
	output reg         pc_load_o,
	output reg  [15:0] pc_new_o,
	output reg  [15:0] sp_new_o,
	output reg  [15:0] y_restore_o,
	output reg  [15:0] x_restore_o,
	output reg  [7:0]  a_restore_o,
	output reg  [7:0]  b_restore_o,
	output reg         regs_restore_o
);

	localparam ST_IDLE  = 3'h0;
	localparam ST_STACK = 3'h1;
	localparam ST_VHI   = 3'h2;
	localparam ST_VLO   = 3'h3;
	localparam ST_VEND  = 3'h4;
	localparam ST_PULL  = 3'h5;
	localparam ST_PEND  = 3'h6;
	localparam ST_VCAP  = 3'h7;

	reg  [2:0]  state_ff;
	reg  [3:0]  cnt_ff;
	reg  [15:0] vec_ff;
	reg         is_nmi_ff;
	reg  [15:0] sp_ff;
	reg  [7:0]  vhi_ff;
	reg         rx_armed_ff;
	reg  [63:0] pull_ff;

	// maskable group requests, index 0 is highest default priority
	wire [17:0] grp_req;
	wire [15:0] grp_vec [0:17];

	assign grp_req[0]  = ~irq_pin_n_i;
	assign grp_req[1]  = periodic_flag_i & periodic_irq_enable_i;
	assign grp_req[2]  = cap_flag_i[0] & cap1_irq_enable_i;
	assign grp_req[3]  = cap_flag_i[1] & cap2_irq_enable_i;
	assign grp_req[4]  = cap_flag_i[2] & cap3_irq_enable_i;
	assign grp_req[5]  = cmp_flag_i[0] & cmp1_irq_enable_i;
	assign grp_req[6]  = cmp_flag_i[1] & cmp2_irq_enable_i;
	assign grp_req[7]  = cmp_flag_i[2] & cmp3_irq_enable_i;
	assign grp_req[8]  = cmp_flag_i[3] & cmp4_irq_enable_i;
	assign grp_req[9]  = cap_flag_i[3] & cap4_cmp5_irq_enable_i;
	assign grp_req[10] = |(t2_cmp_flag_i & t2_cmp_enable_i);
	assign grp_req[11] = t2_c4_flag_i & t2_chan4_irq_enable_i;
	assign grp_req[12] = t1_ovf_flag_i & t1_overflow_enable_i;
	assign grp_req[13] = t2_ovf_flag_i & t2_overflow_enable_i;
	assign grp_req[14] = pa_ovf_flag_i & pulse_ovf_irq_enable_i;
	assign grp_req[15] = pa_edge_flag_i & pulse_edge_irq_enable_i;
	// third timer: four channels on one vector, overflow on its own
	assign grp_req[16] = (|(t3_cc_flag_i & t3_cc_enable_i)) |
		(t3_ovf_flag_i & t3_overflow_enable_i);
	assign grp_req[17] = (sync_done_flag_i & sync_serial_irq_enable_i) |
		((rx_full_flag_i | rx_overrun_flag_i) & rx_irq_enable_i) |
		(tx_empty_flag_i & tx_empty_irq_enable_i) |
		(tx_done_flag_i & tx_done_irq_enable_i) |
		(idle_line_flag_i & idle_line_irq_enable_i);

	wire t3_cc_req  = |(t3_cc_flag_i & t3_cc_enable_i);
	wire sync_req   = sync_done_flag_i & sync_serial_irq_enable_i;

	assign grp_vec[0]  = `IVS_VEC_IRQPIN;
	assign grp_vec[1]  = `IVS_VEC_RTI;
	assign grp_vec[2]  = `IVS_VEC_CAP1;
	assign grp_vec[3]  = `IVS_VEC_CAP2;
	assign grp_vec[4]  = `IVS_VEC_CAP3;
	assign grp_vec[5]  = `IVS_VEC_CMP1;
	assign grp_vec[6]  = `IVS_VEC_CMP2;
	assign grp_vec[7]  = `IVS_VEC_CMP3;
	assign grp_vec[8]  = `IVS_VEC_CMP4;
	assign grp_vec[9]  = `IVS_VEC_C4C5;
	assign grp_vec[10] = `IVS_VEC_T2CMP;
	assign grp_vec[11] = `IVS_VEC_T2C4;
	assign grp_vec[12] = `IVS_VEC_T1OVF;
	assign grp_vec[13] = `IVS_VEC_T2OVF;
	assign grp_vec[14] = `IVS_VEC_PAOVF;
	assign grp_vec[15] = `IVS_VEC_PAEDGE;
	assign grp_vec[16] = t3_cc_req ? `IVS_VEC_T3CC : `IVS_VEC_T3OVF;
	assign grp_vec[17] = sync_req ? `IVS_VEC_SYNC : `IVS_VEC_SER;

	// priority-select codes matching each group
	localparam [89:0] GRP_CODES = {5'h14, 5'h18, 5'h12, 5'h11, 5'h17, 5'h10, 5'h16, 5'h15, 5'h0f,
		5'h0e, 5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h08, 5'h07, 5'h06};

	// promoted group; reserved codes fall back to the level pin
	reg  [17:0] promo;
	reg  [15:0] mask_vec;
	reg         mask_any;
	integer     k;
	always @* begin
		promo = 18'h00000;
		for (k = 0; k < 18; k = k + 1) begin
			if (GRP_CODES[k*5 +: 5] == psel_o)
				promo[k] = 1'b1;
		end
		if (psel_o == 5'h19)
			promo[16] = 1'b1;
		if (psel_o == 5'h13)
			promo[17] = 1'b1;
		if (promo == 18'h00000)
			promo[0] = 1'b1;
		mask_any = |grp_req;
		mask_vec = `IVS_VEC_IRQPIN;
		for (k = 17; k >= 0; k = k - 1) begin
			if (grp_req[k])
				mask_vec = grp_vec[k];
		end
		// promotion changes only the order, never the vector
		for (k = 0; k < 18; k = k + 1) begin
			if (promo[k] && grp_req[k])
				mask_vec = grp_vec[k];
		end
	end

	wire i_mask   = condition_codes_o[`IVS_CC_I];
	wire x_mask   = condition_codes_o[`IVS_CC_X];
	wire nmi_req  = ~nonmaskable_pin_request_n_i & ~x_mask;
	wire wdog_req = wdog_fail_i & ~watchdog_disable_i;
	wire cm_req   = clkmon_fail_i & clock_monitor_enable_i;
	wire mrec     = mask_any & ~i_mask;

	// fixed encoder, reset-class first, then unblocked traps
	reg  [15:0] sel_vec;
	reg         sel_any;
	always @* begin
		sel_any = 1'b1;
		if (cm_req)
			sel_vec = `IVS_VEC_CLKMON;
		else if (wdog_req)
			sel_vec = `IVS_VEC_WDOG;
		else if (nmi_req)
			sel_vec = `IVS_VEC_NMIPIN;
		else if (illegal_op_i)
			sel_vec = `IVS_VEC_ILLOP;
		else if (software_trap_i)
			sel_vec = `IVS_VEC_SWTRAP;
		else if (mrec)
			sel_vec = mask_vec;
		else begin
			sel_vec = `IVS_VEC_RESET;
			sel_any = 1'b0;
		end
	end

	// stacking byte sequence
	reg [7:0] push_byte;
	always @* begin
		case (cnt_ff)
			4'h0: push_byte = pc_i[7:0];
			4'h1: push_byte = pc_i[15:8];
			4'h2: push_byte = y_index_i[7:0];
			4'h3: push_byte = y_index_i[15:8];
			4'h4: push_byte = x_index_i[7:0];
			4'h5: push_byte = x_index_i[15:8];
			4'h6: push_byte = accumulator_a_i;
			4'h7: push_byte = accumulator_b_i;
			default: push_byte = condition_codes_o;
		endcase
	end

	assign cpu_hold_o = (state_ff != ST_IDLE);

	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_ff          <= ST_IDLE;
			cnt_ff            <= 4'h0;
			vec_ff            <= 16'h0000;
			is_nmi_ff         <= 1'b0;
			sp_ff             <= 16'h0000;
			vhi_ff            <= 8'h00;
			rx_armed_ff       <= 1'b0;
			rx_full_clear_o   <= 1'b0;
			pull_ff           <= 64'h0;
			psel_o            <= `IVS_PSEL_RST;
			condition_codes_o <= `IVS_CC_RST;
			mem_addr_o        <= 16'h0000;
			mem_wdata_o       <= 8'h00;
			mem_wr_o          <= 1'b0;
			mem_rd_o          <= 1'b0;
			pc_load_o         <= 1'b0;
			pc_new_o          <= 16'h0000;
			sp_new_o          <= 16'h0000;
			y_restore_o       <= 16'h0000;
			x_restore_o       <= 16'h0000;
			a_restore_o       <= 8'h00;
			b_restore_o       <= 8'h00;
			regs_restore_o    <= 1'b0;
		end else begin
			mem_wr_o       <= 1'b0;
			mem_rd_o       <= 1'b0;
			pc_load_o      <= 1'b0;
			regs_restore_o <= 1'b0;
			rx_full_clear_o <= 1'b0;
			// clear sequence: status read with flag set arms, data read clears
			if (ser_status_rd_i)
				rx_armed_ff <= rx_full_flag_i;
			else if (ser_data_rd_i && rx_armed_ff) begin
				rx_full_clear_o <= 1'b1;
				rx_armed_ff     <= 1'b0;
			end
			// writes only while maskable interrupts are held off
			if (psel_wr_i && i_mask)
				psel_o <= psel_wdata_i;
			if (cc_wr_i && state_ff == ST_IDLE) begin
				// X may go from set to clear, never back from a write
				condition_codes_o <= (cc_wdata_i & 8'hbf) |
					{1'b0, x_mask & cc_wdata_i[`IVS_CC_X], 6'h00};
			end
			case (state_ff)
				ST_IDLE: begin
					cnt_ff <= 4'h0;
					sp_ff  <= sp_i;
					if (rti_i) begin
						state_ff <= ST_PULL;
					end else if (insn_done_i && sel_any) begin
						state_ff  <= ST_STACK;
						vec_ff    <= sel_vec;
						is_nmi_ff <= nmi_req & ~cm_req & ~wdog_req;
					end
				end
				ST_STACK: begin
					mem_wr_o    <= 1'b1;
					mem_addr_o  <= sp_ff - {12'h000, cnt_ff};
					mem_wdata_o <= push_byte;
					if (cnt_ff == `IVS_NSTACK - 4'h1) begin
						condition_codes_o[`IVS_CC_I] <= 1'b1;
						if (is_nmi_ff)
							condition_codes_o[`IVS_CC_X] <= 1'b1;
						state_ff <= ST_VHI;
					end
					cnt_ff <= cnt_ff + 4'h1;
				end
				ST_VHI: begin
					mem_rd_o   <= 1'b1;
					mem_addr_o <= vec_ff;
					state_ff   <= ST_VLO;
				end
				ST_VLO: begin
					mem_rd_o   <= 1'b1;
					mem_addr_o <= vec_ff + 16'h0001;
					state_ff   <= ST_VCAP;
				end
				ST_VCAP: begin
					// read data lag the strobe by one cycle
					vhi_ff   <= mem_rdata_i;
					state_ff <= ST_VEND;
				end
				ST_VEND: begin
					pc_load_o <= 1'b1;
					pc_new_o  <= {vhi_ff, mem_rdata_i};
					sp_new_o  <= sp_ff - `IVS_CC_OFFSET - 16'h0001;
					state_ff  <= ST_IDLE;
				end
				ST_PULL: begin
					// read sp+1 .. sp+9; the first sample is stale and drops out
					if (cnt_ff != 4'h0)
						pull_ff <= {pull_ff[55:0], mem_rdata_i};
					if (cnt_ff == `IVS_NSTACK) begin
						state_ff <= ST_PEND;
					end else begin
						mem_rd_o   <= 1'b1;
						mem_addr_o <= sp_ff + {12'h000, cnt_ff} + 16'h0001;
					end
					cnt_ff <= cnt_ff + 4'h1;
				end
				ST_PEND: begin
					condition_codes_o <= pull_ff[63:56];
					b_restore_o       <= pull_ff[55:48];
					a_restore_o       <= pull_ff[47:40];
					x_restore_o       <= pull_ff[39:24];
					y_restore_o       <= pull_ff[23:8];
					pc_new_o          <= {pull_ff[7:0], mem_rdata_i};
					sp_new_o          <= sp_ff + {12'h000, `IVS_NSTACK};
					regs_restore_o    <= 1'b1;
					pc_load_o         <= 1'b1;
					state_ff          <= ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

endmodule

// ### ivs_defines.vh
/*
 vector addresses, stacking offsets, priority-select codes and reset values
 for the interrupt vectoring and stacking block. assumes 8-bit data, 16-bit
 addresses.
*/
`ifndef IVS_DEFINES_VH
`define IVS_DEFINES_VH

`define IVS_VEC_RESET   16'hfffe
`define IVS_VEC_CLKMON  16'hfffc
`define IVS_VEC_WDOG    16'hfffa
`define IVS_VEC_ILLOP   16'hfff8
`define IVS_VEC_SWTRAP  16'hfff6
`define IVS_VEC_NMIPIN  16'hfff4
`define IVS_VEC_IRQPIN  16'hfff2
`define IVS_VEC_RTI     16'hfff0
`define IVS_VEC_CAP1    16'hffee
`define IVS_VEC_CAP2    16'hffec
`define IVS_VEC_CAP3    16'hffea
`define IVS_VEC_CMP1    16'hffe8
`define IVS_VEC_CMP2    16'hffe6
`define IVS_VEC_CMP3    16'hffe4
`define IVS_VEC_CMP4    16'hffe2
`define IVS_VEC_C4C5    16'hffe0
`define IVS_VEC_T1OVF   16'hffde
`define IVS_VEC_PAOVF   16'hffdc
`define IVS_VEC_PAEDGE  16'hffda
`define IVS_VEC_SYNC    16'hffd8
`define IVS_VEC_SER     16'hffd6
`define IVS_VEC_T2CMP   16'hffd4
`define IVS_VEC_T2C4    16'hffd2
`define IVS_VEC_T2OVF   16'hffd0
`define IVS_VEC_T3CC    16'hffce
`define IVS_VEC_T3OVF   16'hffcc

// number of maskable vector groups, and stacked bytes
`define IVS_NMASK       5'h12
`define IVS_NSTACK      4'h9
`define IVS_CC_OFFSET   16'h0008

// priority-select reset value: external level request on top
`define IVS_PSEL_RST    5'h06

// condition code bit positions
`define IVS_CC_X        6
`define IVS_CC_I        4
`define IVS_CC_RST      8'hd0

`endif

// ### ivs_mem_model.sv
/*
 memory seen by the vectoring block: stores stacked bytes, answers vector
 reads with a fixed pattern. assumes one access a cycle, read data the
 cycle after the strobe.
*/
`timescale 1ns/1ps
module ivs_mem_model (
	// clock
	input  wire        ref_clk_i,
	// memory port of the block
	input  wire [15:0] addr_i,
	input  wire [7:0]  wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output wire [7:0]  rdata_o
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_ff = 8'h00;
	logic       vld_ff  = 1'b0;
	// vector v holds 20xx with xx the low byte of v, high byte at even place
	always @(posedge ref_clk_i) begin
		if (wr_i)
			mem[addr_i] <= wdata_i;
		vld_ff <= rd_i;
		if (rd_i)
			last_ff <= (addr_i >= 16'hffc0) ? (addr_i[0] ? {addr_i[7:1], 1'b0} : 8'h20)
				: mem[addr_i];
	end
	// data stand one cycle only, then the inverse so stale data cannot match
	assign rdata_o = vld_ff ? last_ff : ~last_ff;
endmodule

// ### ivs_top_monitor.sv
/*
 port checker for the vectoring block. assumes the cpu holds sp_i steady
 while the block is busy.
*/
`timescale 1ns/1ps
module ivs_top_monitor (
	// clock and reset
	input wire        ref_clk_i,
	input wire        nrst_i,
	// watched inputs
	input wire        insn_done_i,
	input wire        rti_i,
	input wire        psel_wr_i,
	input wire        ser_data_rd_i,
	input wire [15:0] sp_i,
	// watched outputs
	input wire        cpu_hold_o,
	input wire        mem_wr_o,
	input wire        mem_rd_o,
	input wire [15:0] mem_addr_o,
	input wire [4:0]  psel_o,
	input wire [7:0]  condition_codes_o,
	input wire        rx_full_clear_o,
	input wire        pc_load_o,
	input wire        regs_restore_o,
	input wire [15:0] sp_new_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);

	chk_hold_cause: assert property ($rose(cpu_hold_o) |-> $past(insn_done_i) || $past(rti_i))
		else $error("hold started without a boundary or return");
	chk_wr_nine: assert property ($rose(mem_wr_o) |=> mem_wr_o [*8] ##1 !mem_wr_o)
		else $error("stacking run is not nine writes");
	chk_wr_step: assert property (mem_wr_o && $past(mem_wr_o)
		|-> mem_addr_o == $past(mem_addr_o) - 16'h0001)
		else $error("stack address did not step down by one");
	chk_wr_base: assert property ($rose(mem_wr_o) |-> mem_addr_o == sp_i)
		else $error("first stacked byte not at the stack pointer");
	chk_i_after_cc: assert property ($fell(mem_wr_o) |-> ##[0:1] condition_codes_o[4])
		else $error("mask not set after stacking");
	chk_vec_pair: assert property (mem_rd_o && mem_addr_o >= 16'hffc0 && !mem_addr_o[0]
		|=> mem_rd_o && mem_addr_o == $past(mem_addr_o) + 16'h0001)
		else $error("vector low byte not read after high byte");
	chk_load_sp: assert property (pc_load_o && !regs_restore_o |-> sp_new_o == sp_i - 16'h0009)
		else $error("stack pointer after entry wrong");
	chk_rti_sp: assert property (regs_restore_o |-> pc_load_o && sp_new_o == sp_i + 16'h0009)
		else $error("stack pointer after return wrong");
	chk_psel_lock: assert property (psel_wr_i && !condition_codes_o[4] |=> $stable(psel_o))
		else $error("priority select changed while unmasked");
	chk_clear_cause: assert property (rx_full_clear_o |-> $past(ser_data_rd_i))
		else $error("receive clear without a data read");

	cover property ($rose(mem_wr_o));
	cover property (regs_restore_o);
	cover property (rx_full_clear_o);
	cover property ($changed(psel_o));
endmodule

bind ivs_top ivs_top_monitor ivs_top_monitor_i (.*);

// ### ivs_top_tb_top.sv
/*
 self-checking bench for the vectoring block. assumes the memory model
 answers every read in the next cycle and that all local enables follow en.
*/
`timescale 1ns/1ps
module ivs_top_tb_top;
	logic ref_clk_i = 0, nrst_i = 0, en = 1;
	logic wdog_fail_i = 0, clkmon_fail_i = 0, nonmaskable_pin_request_n_i = 1, irq_pin_n_i = 1;
	logic illegal_op_i = 0, software_trap_i = 0, periodic_flag_i = 0, t1_ovf_flag_i = 0;
	logic t2_c4_flag_i = 0, t2_ovf_flag_i = 0, t3_ovf_flag_i = 0, pa_ovf_flag_i = 0;
	logic pa_edge_flag_i = 0, sync_done_flag_i = 0, rx_full_flag_i = 0, rx_overrun_flag_i = 0;
	logic tx_empty_flag_i = 0, tx_done_flag_i = 0, idle_line_flag_i = 0, ser_status_rd_i = 0;
	logic ser_data_rd_i = 0, psel_wr_i = 0, insn_done_i = 0, rti_i = 0, cc_wr_i = 0;
	logic [3:0] cap_flag_i = 0, cmp_flag_i = 0, t3_cc_flag_i = 0;
	logic [2:0] t2_cmp_flag_i = 0;
	logic [4:0] psel_wdata_i = 0;
	logic [7:0] cc_wdata_i = 0, accumulator_a_i = 8'hde, accumulator_b_i = 8'hf0;
	logic [15:0] sp_i = 16'h01ff, pc_i = 16'h1234, y_index_i = 16'h5678, x_index_i = 16'h9abc;
	wire watchdog_disable_i = 1, clock_monitor_enable_i = 0;
	wire periodic_irq_enable_i = en, cap1_irq_enable_i = en, cap2_irq_enable_i = en;
	wire cap3_irq_enable_i = en, cap4_cmp5_irq_enable_i = en, cmp1_irq_enable_i = en;
	wire cmp2_irq_enable_i = en, cmp3_irq_enable_i = en, cmp4_irq_enable_i = en;
	wire t1_overflow_enable_i = en, t2_chan4_irq_enable_i = en, t2_overflow_enable_i = en;
	wire t3_overflow_enable_i = en, pulse_ovf_irq_enable_i = en, pulse_edge_irq_enable_i = en;
	wire sync_serial_irq_enable_i = en, rx_irq_enable_i = en, tx_empty_irq_enable_i = en;
	wire tx_done_irq_enable_i = en, idle_line_irq_enable_i = en;
	wire [2:0] t2_cmp_enable_i = {3{en}};
	wire [3:0] t3_cc_enable_i = {4{en}};
	wire rx_full_clear_o, mem_wr_o, mem_rd_o, cpu_hold_o, pc_load_o, regs_restore_o;
	wire [4:0] psel_o;
	wire [7:0] condition_codes_o, mem_wdata_o, mem_rdata_i, a_restore_o, b_restore_o;
	wire [15:0] mem_addr_o, pc_new_o, sp_new_o, y_restore_o, x_restore_o;
	int n_mismatch = 0, n_compared = 0;
	localparam logic [7:0] vec_lo [29] = '{8'hf2, 8'hf0, 8'hee, 8'hec, 8'hea, 8'he8, 8'he6,
		8'he4, 8'he2, 8'he0, 8'hde, 8'hdc, 8'hda, 8'hd8, 8'hd6, 8'hd6, 8'hd6, 8'hd6, 8'hd6,
		8'hd4, 8'hd4, 8'hd4, 8'hd2, 8'hd0, 8'hce, 8'hce, 8'hce, 8'hce, 8'hcc};

	ivs_top ivs_top_i (.*);
	ivs_mem_model ivs_mem_model_i (.ref_clk_i(ref_clk_i), .addr_i(mem_addr_o),
		.wdata_i(mem_wdata_o), .wr_i(mem_wr_o), .rd_i(mem_rd_o), .rdata_o(mem_rdata_i));

	initial begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	task automatic end_of_test;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic set_src(input int k, input logic v);
		case (k)
			0: irq_pin_n_i <= ~v;
			1: periodic_flag_i <= v;
			2, 3, 4: cap_flag_i[k-2] <= v;
			5, 6, 7, 8: cmp_flag_i[k-5] <= v;
			9: cap_flag_i[3] <= v;
			10: t1_ovf_flag_i <= v;
			11: pa_ovf_flag_i <= v;
			12: pa_edge_flag_i <= v;
			13: sync_done_flag_i <= v;
			14: rx_full_flag_i <= v;
			15: rx_overrun_flag_i <= v;
			16: tx_empty_flag_i <= v;
			17: tx_done_flag_i <= v;
			18: idle_line_flag_i <= v;
			19, 20, 21: t2_cmp_flag_i[k-19] <= v;
			22: t2_c4_flag_i <= v;
			23: t2_ovf_flag_i <= v;
			24, 25, 26, 27: t3_cc_flag_i[k-24] <= v;
			default: t3_ovf_flag_i <= v;
		endcase
	endtask

	// p selects the priority field, else the condition codes
	task automatic wr(input logic p, input logic [7:0] d);
		psel_wr_i <= p;
		cc_wr_i <= !p;
		psel_wdata_i <= d[4:0];
		cc_wdata_i <= d;
		@(posedge ref_clk_i);
		psel_wr_i <= 0;
		cc_wr_i <= 0;
		@(posedge ref_clk_i);
	endtask

	task automatic wait_load;
		int i;
		for (i = 0; i < 40 && pc_load_o !== 1'b1; i++)
			@(posedge ref_clk_i);
		if (i == 40) begin
			n_mismatch++;
			$display("[FAIL] pc load expected 1 seen timeout");
			end_of_test;
		end
	endtask

	task automatic quiet(input string n);
		insn_done_i <= 1;
		@(posedge ref_clk_i);
		insn_done_i <= 0;
		repeat (4) begin
			@(posedge ref_clk_i);
			cmp(n, 16'h0, cpu_hold_o);
		end
	endtask

	task automatic serve(input logic [7:0] v);
		int i;
		logic [7:0] stk [9];
		stk = '{8'h34, 8'h12, 8'h78, 8'h56, 8'hbc, 8'h9a, 8'hde, 8'hf0, condition_codes_o};
		repeat (3) @(posedge ref_clk_i);
		cmp("hold before boundary", 16'h0, cpu_hold_o);
		insn_done_i <= 1;
		@(posedge ref_clk_i);
		insn_done_i <= 0;
		wait_load;
		cmp("vector", {8'h20, v}, pc_new_o);
		cmp("sp", 16'h01f6, sp_new_o);
		for (i = 0; i < 9; i++)
			cmp("stack", stk[i], ivs_mem_model_i.mem[16'h01ff - i]);
		cmp("i set", 16'h1, condition_codes_o[4]);
		@(posedge ref_clk_i);
	endtask

	task automatic t_reset;
		cmp("psel reset", 16'h06, psel_o);
		cmp("cc reset", 16'hd0, condition_codes_o);
		wr(0, 8'h00);
		wr(0, 8'h50);
		cmp("x sticky", 16'h10, condition_codes_o);
	endtask

	task automatic t_mask;
		set_src(1, 1);
		quiet("masked");
		wr(1, 8'h08);
		cmp("psel write", 16'h08, psel_o);
		wr(0, 8'h00);
		wr(1, 8'h07);
		cmp("psel locked", 16'h08, psel_o);
		set_src(1, 0);
	endtask

	task automatic t_vectors;
		for (int k = 0; k < 29; k++) begin
			set_src(k, 1);
			serve(vec_lo[k]);
			set_src(k, 0);
			wr(0, 8'h00);
			quiet("withdrawn");
		end
	endtask

	task automatic t_priority;
		set_src(0, 1);
		set_src(2, 1);
		serve(8'hee);
		wr(1, 8'h06);
		wr(0, 8'h00);
		serve(8'hf2);
		set_src(0, 0);
		set_src(2, 0);
		wr(0, 8'h00);
		en <= 0;
		set_src(22, 1);
		quiet("local enable");
		en <= 1;
		serve(8'hd2);
		set_src(22, 0);
	endtask

	task automatic t_nonmask;
		wr(0, 8'h10);
		software_trap_i <= 1;
		serve(8'hf6);
		software_trap_i <= 0;
		wr(0, 8'h10);
		illegal_op_i <= 1;
		serve(8'hf8);
		illegal_op_i <= 0;
		wr(0, 8'h00);
		nonmaskable_pin_request_n_i <= 0;
		set_src(0, 1);
		serve(8'hf4);
		cmp("x and i set", 16'h50, condition_codes_o & 8'h50);
		nonmaskable_pin_request_n_i <= 1;
		set_src(0, 0);
		sp_i <= 16'h01f6;
		rti_i <= 1;
		@(posedge ref_clk_i);
		rti_i <= 0;
		wait_load;
		cmp("y restore", 16'h5678, y_restore_o);
		cmp("x restore", 16'h9abc, x_restore_o);
		cmp("a restore", 16'hde, a_restore_o);
		cmp("b restore", 16'hf0, b_restore_o);
		cmp("pc restore", 16'h1234, pc_new_o);
		cmp("restore flag", 16'h1, regs_restore_o);
		@(posedge ref_clk_i);
		cmp("cc restore", 16'h00, condition_codes_o);
		sp_i <= 16'h01ff;
	endtask

	task automatic t_serial;
		int c;
		c = 0;
		rx_full_flag_i <= 1;
		ser_status_rd_i <= 1;
		@(posedge ref_clk_i);
		ser_status_rd_i <= 0;
		ser_data_rd_i <= 1;
		@(posedge ref_clk_i);
		ser_data_rd_i <= 0;
		repeat (4) begin
			@(posedge ref_clk_i);
			if (rx_full_clear_o === 1'b1)
				c++;
		end
		cmp("rx clear", 16'h1, c[15:0]);
		rx_full_flag_i <= 0;
	endtask

	initial begin
		repeat (20) @(posedge ref_clk_i);
		nrst_i <= 1;
		@(posedge ref_clk_i);
		t_reset;
		t_mask;
		t_vectors;
		t_priority;
		t_nonmask;
		t_serial;
		end_of_test;
	end
endmodule
